// ==== core/smwr_defines.svh ====
// constants for the halt wake recovery block
`ifndef SMWR_DEFINES_SVH
`define SMWR_DEFINES_SVH
`define SMWR_SUBREG_WAKE_EN 8'h05
`define SMWR_WAKE_EN_RESET 8'h00
`define SMWR_RECOV_DELAY_NS 2000
`define SMWR_CLK_PERIOD_NS 25
`define SMWR_RECOV_CYCLES ((`SMWR_RECOV_DELAY_NS + `SMWR_CLK_PERIOD_NS - 1) / `SMWR_CLK_PERIOD_NS)
`define SMWR_CNT_W 8
`endif

// ==== core/smwr_pkg.sv ====
// types for the halt wake recovery block
package smwr_pkg;
  typedef enum logic [1:0] {
    SMWR_RUN,
    SMWR_HALT,
    SMWR_RECOVER
  } smwr_state_t;
endpackage

// ==== core/smwr_sync_if.sv ====
// carrier for synchronised pin levels between sync stage and main logic
`timescale 1ns/10ps
`default_nettype none
interface smwr_sync_if;
  logic [7:0] port_lvl;
  logic [7:0] port_chg;
  logic rst_lvl;
  logic dbg_lvl;
  modport src (output port_lvl, output port_chg, output rst_lvl, output dbg_lvl);
  modport dst (input port_lvl, input port_chg, input rst_lvl, input dbg_lvl);
endinterface
`default_nettype wire

// ==== core/smwr_sync.sv ====
// three-stage pin synchroniser with change detect
`timescale 1ns/10ps
`default_nettype none
module smwr_sync (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // raw pins
  input wire logic [7:0] i_port,
  input wire logic i_rst_pin_n,
  input wire logic i_dbg_pin,
  // synchronised levels
  smwr_sync_if.src o_sync
);
  // ---------------------------------------------------------------
  // three sync flops and a level flop per pin; stage one is read only by stage two
  // ---------------------------------------------------------------
  logic [9:0] s1_r, s2_r, s3_r, lvl_r;
  logic [9:0] s1_nxt, s2_nxt, s3_nxt, lvl_nxt, chg;
  // a change counts once stages two and three agree on a new level
  always_comb begin
    s1_nxt = {i_dbg_pin, i_rst_pin_n, i_port};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
    lvl_nxt = lvl_r;
    chg = '0;
    for (int k = 0; k < 10; k++) begin
      if ((s2_r[k] == s3_r[k]) && (s3_r[k] != lvl_r[k])) begin
        lvl_nxt[k] = s3_r[k];
        chg[k] = 1'b1;
      end
    end
  end
  // pins idle high after reset (pull-ups)
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s1_r <= 10'h3FF;
      s2_r <= 10'h3FF;
      s3_r <= 10'h3FF;
      lvl_r <= 10'h3FF;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      lvl_r <= lvl_nxt;
    end
  end
  assign o_sync.port_lvl = lvl_r[7:0];
  assign o_sync.port_chg = chg[7:0];
  assign o_sync.rst_lvl = lvl_r[8];
  assign o_sync.dbg_lvl = lvl_r[9];
endmodule // smwr_sync
`default_nettype wire

// ==== core/smwr_top.sv ====
// halt mode wake recovery: sources, reset cause flags, per-pin wake enables
// Operation
// - set halt-recovery flag after every recovery
// - watchdog expiry in halt: recover, set flags
// - watchdog interrupt serviced after recovery, if enabled
// - enabled pin edge either way starts recovery
// - reset pin in halt: full system reset
// - debug pin low in halt: system reset
// - input latch frozen; captures only persisting levels
// - short pulse wakes without latch or interrupt
// - eight enable bits, one per pin, reset zero
`timescale 1ns/10ps
`default_nettype none
`include "smwr_defines.svh"
module smwr_top import smwr_pkg::*; (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // port register access: address register and control register
  input wire logic i_addr_wr,
  input wire logic i_ctl_wr,
  input wire logic [7:0] i_wdata,
  // core status
  input wire logic i_halt_req,
  input wire logic i_wdt_expire,
  input wire logic i_wdt_irq_mode,
  input wire logic i_irq_global_en,
  input wire logic i_flag_clr,
  // pins
  input wire logic [7:0] i_port,
  input wire logic i_rst_pin_n,
  input wire logic i_debug_pin,
  // outputs
  output logic [7:0] o_ctl_rdata,
  output logic [7:0] o_port_input_latch,
  output logic [7:0] o_pin_irq,
  output logic o_halted,
  output logic o_sys_reset,
  output logic o_wdt_irq,
  output logic o_halt_recovery_flag,
  output logic o_watchdog_cause_flag
);
  // ---------------------------------------------------------------
  // synchronised pins
  // ---------------------------------------------------------------
  smwr_sync_if sync_bus ();
  smwr_sync u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_port(i_port),
    .i_rst_pin_n(i_rst_pin_n),
    .i_dbg_pin(i_debug_pin),
    .o_sync(sync_bus)
  );
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // recovery delay loaded on wake, counted down to one
  localparam logic [`SMWR_CNT_W-1:0] RECOV_CNT = `SMWR_CNT_W'(`SMWR_RECOV_CYCLES);
  // sequencer state
  smwr_state_t state_r, state_nxt;
  logic [`SMWR_CNT_W-1:0] cnt_r, cnt_nxt; // recovery delay counter
  // register access: the address register picks the subregister
  logic [7:0] subaddr_r, subaddr_nxt; // port address register
  // one enable bit per pin; a zero keeps that pin out of the wake detector
  logic [7:0] port_wake_source_enable_r, port_wake_source_enable_nxt;
  // port side results
  logic [7:0] latch_r, latch_nxt; // port input latch
  logic [7:0] irq_r, irq_nxt; // pin edge pulses
  // read data is registered, so it trails an address change by one cycle
  logic [7:0] rdata_r, rdata_nxt;
  // cause flags stay set until software clears them
  logic stop_flag_r, stop_flag_nxt; // halt-recovery cause flag
  logic wdt_flag_r, wdt_flag_nxt; // watchdog cause flag
  // the interrupt is held here until the block runs with interrupts enabled, then pulsed once
  logic wdt_pend_r, wdt_pend_nxt; // watchdog interrupt held over recovery
  logic wdt_irq_r, wdt_irq_nxt;
  // one-cycle request toward the system reset generator
  logic sysrst_r, sysrst_nxt;
  // halted covers recovery too: the core stays stopped until the delay ends
  logic halted_r, halted_nxt;
  // combined wake request from enabled pins
  logic pin_wake;
  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    // hold everything but the irq and reset pulses, which default to zero, unless a branch below says otherwise
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    subaddr_nxt = subaddr_r;
    port_wake_source_enable_nxt = port_wake_source_enable_r;
    latch_nxt = latch_r;
    irq_nxt = 8'h00;
    stop_flag_nxt = stop_flag_r;
    wdt_flag_nxt = wdt_flag_r;
    wdt_pend_nxt = wdt_pend_r;
    wdt_irq_nxt = 1'b0;
    sysrst_nxt = 1'b0;
    // only enabled pins can wake; others are ignored
    pin_wake = |(sync_bus.port_chg & port_wake_source_enable_r);
    // address then control register access selects the subregister
    if (i_addr_wr) begin
      subaddr_nxt = i_wdata;
    end
    // a control write is decoded against the address held before this edge
    if (i_ctl_wr && (subaddr_r == `SMWR_SUBREG_WAKE_EN)) begin
      port_wake_source_enable_nxt = i_wdata;
    end
    // software clear first so that hardware set below wins
    if (i_flag_clr) begin
      stop_flag_nxt = 1'b0;
      wdt_flag_nxt = 1'b0;
    end
    case (state_r)
      SMWR_RUN: begin
        // latch follows pins and edges raise interrupts while running
        latch_nxt = sync_bus.port_lvl;
        irq_nxt = sync_bus.port_chg;
        // a halt request while halted or recovering is ignored
        if (i_halt_req) begin
          state_nxt = SMWR_HALT;
        end
      end
      SMWR_HALT: begin
        // latch frozen while halted; pulses never reach it
        // pin resets outrank the watchdog, the watchdog outranks pins
        // a reset pin event is not a recovery, so no cause flag is set
        if (!sync_bus.rst_lvl) begin
          sysrst_nxt = 1'b1;
          state_nxt = SMWR_RUN;
        end else if (!sync_bus.dbg_lvl) begin
          sysrst_nxt = 1'b1;
          state_nxt = SMWR_RUN;
        end else if (i_wdt_expire) begin
          wdt_flag_nxt = 1'b1;
          wdt_pend_nxt = i_wdt_irq_mode;
          state_nxt = SMWR_RECOVER;
          cnt_nxt = RECOV_CNT;
        end else if (pin_wake) begin
          state_nxt = SMWR_RECOVER;
          cnt_nxt = RECOV_CNT;
        end
      end
      SMWR_RECOVER: begin
        // pin changes during the delay are ignored; only the final level counts
        if (cnt_r > `SMWR_CNT_W'(1)) begin
          cnt_nxt = cnt_r - `SMWR_CNT_W'(1);
        end else begin
          // only a level still present now reaches the latch, no irq
          latch_nxt = sync_bus.port_lvl;
          stop_flag_nxt = 1'b1;
          // the core restarts on the next edge
          state_nxt = SMWR_RUN;
        end
      end
      default: begin
        // unused encoding falls back to running
        state_nxt = SMWR_RUN;
      end
    endcase
    // watchdog interrupt only after recovery and only if enabled
    // a held interrupt waits here while interrupts are off
    if (wdt_pend_r && (state_r == SMWR_RUN) && i_irq_global_en) begin
      wdt_irq_nxt = 1'b1;
      wdt_pend_nxt = 1'b0;
    end
    // follows the next state so it rises on the edge that takes the request
    halted_nxt = (state_nxt != SMWR_RUN);
    // any other subregister index reads as zero in this block
    rdata_nxt = (subaddr_r == `SMWR_SUBREG_WAKE_EN) ? port_wake_source_enable_r : 8'h00;
  end
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // asynchronous reset loads constants only; the sync stage presets pins high
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // enables cleared so no pin can wake a freshly reset device
      state_r <= SMWR_RUN;
      cnt_r <= '0;
      subaddr_r <= 8'h00;
      port_wake_source_enable_r <= `SMWR_WAKE_EN_RESET;
      latch_r <= 8'h00;
      irq_r <= 8'h00;
      rdata_r <= 8'h00;
      stop_flag_r <= 1'b0;
      wdt_flag_r <= 1'b0;
      wdt_pend_r <= 1'b0;
      wdt_irq_r <= 1'b0;
      sysrst_r <= 1'b0;
      halted_r <= 1'b0;
    end else begin
      // every register loads its next value on every edge
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      subaddr_r <= subaddr_nxt;
      port_wake_source_enable_r <= port_wake_source_enable_nxt;
      latch_r <= latch_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      stop_flag_r <= stop_flag_nxt;
      wdt_flag_r <= wdt_flag_nxt;
      wdt_pend_r <= wdt_pend_nxt;
      wdt_irq_r <= wdt_irq_nxt;
      sysrst_r <= sysrst_nxt;
      halted_r <= halted_nxt;
    end
  end
  // all outputs straight from flops
  // register read port
  assign o_ctl_rdata = rdata_r;
  // port side
  assign o_port_input_latch = latch_r;
  assign o_pin_irq = irq_r;
  // status toward the core
  assign o_halted = halted_r;
  assign o_sys_reset = sysrst_r;
  assign o_wdt_irq = wdt_irq_r;
  // cause flags
  assign o_halt_recovery_flag = stop_flag_r;
  assign o_watchdog_cause_flag = wdt_flag_r;
endmodule // smwr_top
`default_nettype wire

// ==== verification/smwr_top_chk.sv ====
// assertions on the halt wake recovery ports
`timescale 1ns/10ps
`default_nettype none
module smwr_top_chk (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // core status and pins
  input wire logic i_wdt_expire,
  input wire logic i_wdt_irq_mode,
  input wire logic i_irq_global_en,
  input wire logic i_rst_pin_n,
  input wire logic i_debug_pin,
  // outputs under watch
  input wire logic [7:0] o_port_input_latch,
  input wire logic [7:0] o_pin_irq,
  input wire logic o_halted,
  input wire logic o_sys_reset,
  input wire logic o_wdt_irq,
  input wire logic o_halt_recovery_flag,
  input wire logic o_watchdog_cause_flag
);
  // one clock domain, so clock and reset are set once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_wdt; o_halted && i_wdt_expire && i_rst_pin_n && i_debug_pin |=> o_watchdog_cause_flag; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog flag missing");
  // a system reset also ends the halt but must not count as a recovery
  property p_rec; $fell(o_halted) && !o_sys_reset && !$past(o_sys_reset) |-> ##[0:82] o_halt_recovery_flag; endproperty
  a_rec: assert property (p_rec) else $error("recovery flag missing");
  property p_irq; o_wdt_irq |-> o_halt_recovery_flag && $past(i_irq_global_en && i_wdt_irq_mode); endproperty
  a_irq: assert property (p_irq) else $error("watchdog irq out of turn");
  property p_rst; o_halted && $fell(i_rst_pin_n) |-> ##[1:6] o_sys_reset; endproperty
  a_rst: assert property (p_rst) else $error("reset pin ignored");
  property p_dbg; o_halted && $fell(i_debug_pin) |-> ##[1:6] o_sys_reset; endproperty
  a_dbg: assert property (p_dbg) else $error("debug pin ignored");
  property p_pulse; o_sys_reset |=> !o_sys_reset; endproperty
  a_pulse: assert property (p_pulse) else $error("system reset too long");
  property p_pinirq; o_halted |-> o_pin_irq == 8'h00; endproperty
  a_pinirq: assert property (p_pinirq) else $error("pin irq in halt");
  property p_latch; o_halted |-> $stable(o_port_input_latch); endproperty
  a_latch: assert property (p_latch) else $error("latch moved in halt");
endmodule // smwr_top_chk
`default_nettype wire

// ==== verification/smwr_pins.sv ====
// pin-side model: port pins, reset pin and debug pin
`timescale 1ns/10ps
`default_nettype none
module smwr_pins (
  // clock used to place pin changes
  input wire logic i_clk,
  // pins toward the block
  output var logic [7:0] o_port,
  output var logic o_rst_pin_n,
  output var logic o_debug_pin
);
  // pins idle high, as the sync stage expects after reset
  initial begin
    o_port = 8'hFF;
    o_rst_pin_n = 1'b1;
    o_debug_pin = 1'b1;
  end
  // changes land just after an edge; the sync stage sees them 3-4 edges later
  task automatic drive(input logic [7:0] p, input logic r, input logic d);
    @(posedge i_clk);
    o_port <= p;
    o_rst_pin_n <= r;
    o_debug_pin <= d;
  endtask
endmodule // smwr_pins
`default_nettype wire

// ==== verification/test_smwr_top.sv ====
// testbench for the halt wake recovery block
`timescale 1ns/10ps
`default_nettype none
module test_smwr_top;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_addr_wr = 1'b0, i_ctl_wr = 1'b0, i_halt_req = 1'b0, i_wdt_expire = 1'b0;
  logic i_wdt_irq_mode = 1'b1, i_irq_global_en = 1'b1, i_flag_clr = 1'b0, i_rst_pin_n, i_debug_pin, got;
  logic [7:0] i_wdata = 8'h00, i_port, o_ctl_rdata, o_port_input_latch, o_pin_irq, irq_seen = 8'h00, base;
  logic o_halted, o_sys_reset, o_wdt_irq, o_halt_recovery_flag, o_watchdog_cause_flag, wirq_seen = 1'b0;
  int n_fail = 0, checked = 0, cyc_n = 0;
  smwr_top smwr_top_i (.i_clk, .i_rst_n, .i_addr_wr, .i_ctl_wr, .i_wdata, .i_halt_req, .i_wdt_expire,
    .i_wdt_irq_mode, .i_irq_global_en, .i_flag_clr, .i_port, .i_rst_pin_n, .i_debug_pin, .o_ctl_rdata,
    .o_port_input_latch, .o_pin_irq, .o_halted, .o_sys_reset, .o_wdt_irq, .o_halt_recovery_flag, .o_watchdog_cause_flag);
  smwr_pins smwr_pins_i (.i_clk, .o_port(i_port), .o_rst_pin_n(i_rst_pin_n), .o_debug_pin(i_debug_pin));
  always #12.5 i_clk = ~i_clk;
  // sticky record of interrupt pulses, which stand one cycle only
  always @(posedge i_clk) begin
    irq_seen <= irq_seen | o_pin_irq;
    wirq_seen <= wirq_seen | o_wdt_irq;
    cyc_n++;
    if (cyc_n == 5000) begin
      n_fail++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  // clear flags and enter halt together; set wins over clear
  task automatic halt();
    i_flag_clr <= 1'b1;
    i_halt_req <= 1'b1;
    cyc(1);
    i_flag_clr <= 1'b0;
    i_halt_req <= 1'b0;
    cyc(2);
    chk("halted", 8'h01, {7'h00, o_halted});
  endtask
  // bounded wait for a completed recovery
  task automatic wait_rec();
    repeat (150) if (!(o_halt_recovery_flag === 1'b1 && o_halted === 1'b0)) cyc(1);
    chk("recovery flag", 8'h01, {7'h00, o_halt_recovery_flag});
  endtask
  task automatic wr(input logic ctl, input logic [7:0] d);
    i_addr_wr <= !ctl;
    i_ctl_wr <= ctl;
    i_wdata <= d;
    cyc(1);
    i_addr_wr <= 1'b0;
    i_ctl_wr <= 1'b0;
    cyc(3);
  endtask
  task automatic t_regs();
    wr(1'b0, 8'h05);
    chk("enable reset", 8'h00, o_ctl_rdata);
    wr(1'b1, 8'h01);
    chk("enable", 8'h01, o_ctl_rdata);
    wr(1'b0, 8'h04);
    chk("other subreg", 8'h00, o_ctl_rdata);
    wr(1'b0, 8'h05);
    chk("enable back", 8'h01, o_ctl_rdata);
    $display("test regs done");
  endtask
  // a disabled pin moves; an enabled one then wakes the block
  task automatic t_pin();
    halt();
    smwr_pins_i.drive(8'hFD, 1'b1, 1'b1);
    cyc(40);
    smwr_pins_i.drive(8'hFF, 1'b1, 1'b1);
    cyc(60);
    chk("still halted", 8'h01, {7'h00, o_halted});
    smwr_pins_i.drive(8'hFE, 1'b1, 1'b1);
    wait_rec();
    chk("latch", 8'hFE, o_port_input_latch);
    $display("test pin done");
  endtask
  task automatic t_pulse();
    halt();
    base = irq_seen;
    smwr_pins_i.drive(8'hFF, 1'b1, 1'b1);
    cyc(4);
    smwr_pins_i.drive(8'hFE, 1'b1, 1'b1);
    wait_rec();
    cyc(3);
    chk("latch after pulse", 8'hFE, o_port_input_latch);
    chk("pin irq", base, irq_seen);
    smwr_pins_i.drive(8'hFF, 1'b1, 1'b1);
    cyc(8);
    chk("pin irq run", 8'h01, irq_seen & ~base);
    chk("latch run", 8'hFF, o_port_input_latch);
    smwr_pins_i.drive(8'hFE, 1'b1, 1'b1);
    cyc(8);
    $display("test pulse done");
  endtask
  task automatic t_wdt();
    halt();
    i_wdt_expire <= 1'b1;
    cyc(1);
    i_wdt_expire <= 1'b0;
    cyc(1);
    chk("watchdog flag", 8'h01, {7'h00, o_watchdog_cause_flag});
    wait_rec();
    cyc(3);
    chk("watchdog irq", 8'h01, {7'h00, wirq_seen});
    $display("test watchdog done");
  endtask
  // s=0 reset pin low, s=1 debug pin low
  task automatic t_sysrst();
    for (int s = 0; s < 2; s++) begin
      halt();
      got = 1'b0;
      smwr_pins_i.drive(8'hFE, s[0], !s[0]);
      repeat (10) begin
        cyc(1);
        got = got | o_sys_reset;
      end
      chk("system reset", 8'h01, {7'h00, got});
      chk("left halt", 8'h00, {7'h00, o_halted});
      smwr_pins_i.drive(8'hFE, 1'b1, 1'b1);
      cyc(10);
    end
    $display("test system reset done");
  endtask
  task automatic summarize();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    cyc(6);
    i_rst_n <= 1'b1;
    cyc(1);
    t_regs();
    t_pin();
    t_pulse();
    t_wdt();
    t_sysrst();
    summarize();
  end
endmodule // test_smwr_top
bind smwr_top smwr_top_chk smwr_top_chk_i (.i_clk, .i_rst_n, .i_wdt_expire, .i_wdt_irq_mode, .i_irq_global_en,
  .i_rst_pin_n, .i_debug_pin, .o_port_input_latch, .o_pin_irq, .o_halted, .o_sys_reset, .o_wdt_irq,
  .o_halt_recovery_flag, .o_watchdog_cause_flag);
`default_nettype wire
